// *** rtl/ocx_pkg.sv ***
// shared constants for the on-chip ram crossbar
package ocx_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned N_DSP = 4;
  localparam int unsigned PORTS_PER_DSP = 3;
  localparam int unsigned PORTS_RISC = 2;
  localparam int unsigned PORTS_XFER = 1;
  localparam int unsigned N_REQ = 15;
  localparam int unsigned N_BANK = 16;
  localparam int unsigned BANK_SHIFT = 11;
  localparam int unsigned REQ_W = 4;
  localparam int unsigned BANK_W = 4;
  localparam logic [31:0] INTERNAL_LIMIT = 32'h0200_0000;
  localparam logic [31:0] REG_BASE = 32'h0100_0000;
  localparam logic [31:0] VIDEO_BASE = 32'h0100_0100;
  localparam logic [31:0] REG_SPAN_MASK = 32'hFFFF_FF00;
endpackage

// *** rtl/ocx_crossbar.sv ***
// crossbar from all requesters to ram banks, plus register path
module ocx_crossbar #(
  parameter int unsigned NB = ocx_pkg::N_BANK
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ocx_pkg::N_REQ-1:0] req_valid,
  input wire logic [ocx_pkg::N_REQ*ocx_pkg::ADDR_W-1:0] req_addr,
  output logic [ocx_pkg::N_REQ-1:0] req_grant,
  output logic [ocx_pkg::N_REQ-1:0] req_external,
  output logic [NB-1:0] bank_en,
  output logic [NB*ocx_pkg::ADDR_W-1:0] bank_addr,
  output logic [NB*ocx_pkg::REQ_W-1:0] bank_owner,
  input wire logic risc_reg_valid,
  input wire logic risc_reg_write,
  input wire logic [ocx_pkg::ADDR_W-1:0] risc_reg_addr,
  input wire logic [ocx_pkg::DATA_W-1:0] risc_reg_wdata,
  output logic risc_reg_ready,
  output logic [ocx_pkg::DATA_W-1:0] risc_reg_rdata,
  output logic xfer_reg_sel,
  output logic video_reg_sel,
  output logic periph_reg_write,
  output logic [7:0] periph_reg_offset,
  output logic [ocx_pkg::DATA_W-1:0] periph_reg_wdata,
  input wire logic [ocx_pkg::DATA_W-1:0] xfer_reg_rdata,
  input wire logic [ocx_pkg::DATA_W-1:0] video_reg_rdata
);
  localparam int unsigned NR = ocx_pkg::N_REQ;
  localparam int unsigned AW = ocx_pkg::ADDR_W;
  localparam int unsigned RW = ocx_pkg::REQ_W;
  localparam int unsigned BW = ocx_pkg::BANK_W;

  // release passes two flops so deassertion never lands near an edge
  logic rst_s1_reg;
  logic rst_s2_reg;
  logic rst_s1_next;
  logic rst_s2_next;
  always_comb
  begin
    rst_s1_next = 1'b1;
    rst_s2_next = rst_s1_reg;
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= rst_s1_next;
      rst_s2_reg <= rst_s2_next;
    end
  end
  wire logic rst_sync_n = rst_s2_reg;

  // internal window: top seven address bits all zero
  function automatic logic is_internal(input logic [AW-1:0] a);
    is_internal = (a < ocx_pkg::INTERNAL_LIMIT);
  endfunction

  // four address bits pick the bank; NB below sixteen strands top banks
  function automatic logic [ocx_pkg::BANK_W-1:0] bank_of(
    input logic [AW-1:0] a);
    logic [AW-1:0] s;
    s = a >> ocx_pkg::BANK_SHIFT;
    bank_of = s[ocx_pkg::BANK_W-1:0];
  endfunction

  // register block hit: address equal to base above the offset byte
  function automatic logic in_span(
    input logic [AW-1:0] a,
    input logic [AW-1:0] base);
    in_span = ((a & ocx_pkg::REG_SPAN_MASK) == base);
  endfunction

  // wrap a port index around the requester ring
  function automatic int unsigned ring_step(
    input int unsigned base,
    input int unsigned step);
    ring_step = (base + step) % NR;
  endfunction

  // port r presents a ram request for bank b in this cycle
  function automatic logic wants_bank(
    input logic [NR-1:0] reqs,
    input logic [NR*BW-1:0] banks,
    input int unsigned r,
    input int unsigned b);
    wants_bank = reqs[r] &&
      (banks[r*BW +: BW] == BW'(b));
  endfunction

  // ports 0..11 dsp (3 each), 12..13 risc, 14 transfer
  logic [NR-1:0] ram_req;
  logic [NR*ocx_pkg::BANK_W-1:0] req_bank;
  always_comb
  begin
    for (int r = 0; r < NR; r++)
    begin
      ram_req[r] = req_valid[r] && is_internal(req_addr[r*AW +: AW])
        && (req_addr[r*AW +: AW] < ocx_pkg::REG_BASE);
      // register window counts as neither ram nor external
      req_external[r] = req_valid[r] && !is_internal(req_addr[r*AW +: AW]);
      req_bank[r*ocx_pkg::BANK_W +: ocx_pkg::BANK_W] =
        bank_of(req_addr[r*AW +: AW]);
    end
  end

  // one pointer per bank; all fifteen ports arbitrated in parallel
  logic [NB*RW-1:0] ptr_reg;
  logic [NB*RW-1:0] ptr_next;
  logic [NR-1:0] grant_c;
  logic [NB-1:0] en_c;
  logic [NB*AW-1:0] baddr_c;
  logic [NB*RW-1:0] owner_c;
  always_comb
  begin
    int unsigned cand;
    int unsigned nreq;
    logic found;
    cand = 0;
    nreq = 0;
    found = 1'b0;
    ptr_next = ptr_reg;
    grant_c = '0;
    en_c = '0;
    baddr_c = '0;
    owner_c = '0;
    for (int unsigned b = 0; b < NB; b++)
    begin
      found = 1'b0;
      nreq = 0;
      for (int unsigned r = 0; r < NR; r++)
        if (wants_bank(ram_req, req_bank, r, b))
          nreq++;
      for (int unsigned k = 0; k < NR; k++)
      begin
        cand = ring_step(32'(ptr_reg[b*RW +: RW]), k);
        if (!found && wants_bank(ram_req, req_bank, cand, b))
        begin
          found = 1'b1;
          grant_c[cand] = 1'b1;
          en_c[b] = 1'b1;
          baddr_c[b*AW +: AW] = req_addr[cand*AW +: AW];
          owner_c[b*RW +: RW] = RW'(cand);
          // a lone requester leaves the pointer alone, so uncontested
          // traffic never reorders the others' turn
          if (nreq > 1)
            ptr_next[b*RW +: RW] = RW'(ring_step(cand, 1));
        end
      end
    end
  end

  // routing is combinational so the address of this cycle is used
  assign req_grant = grant_c;
  assign bank_en = en_c;
  assign bank_addr = baddr_c;
  assign bank_owner = owner_c;

  // the per-bank pointers are the only state on the crossbar side
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      ptr_reg <= '0;
    else
      ptr_reg <= ptr_next;
  end

  // register path bypasses the crossbar; one-cycle read latency
  // ready answers every request, unmapped ones too, so the core never
  // stalls; read data holds across writes until the next read
  logic hit_x;
  logic hit_v;
  logic ack_reg;
  logic ack_next;
  logic [ocx_pkg::DATA_W-1:0] rdata_reg;
  logic [ocx_pkg::DATA_W-1:0] rdata_next;
  always_comb
  begin
    hit_x = risc_reg_valid && in_span(risc_reg_addr, ocx_pkg::REG_BASE);
    hit_v = risc_reg_valid && in_span(risc_reg_addr, ocx_pkg::VIDEO_BASE);
    ack_next = risc_reg_valid;
    rdata_next = rdata_reg;
    if (risc_reg_valid && !risc_reg_write)
      rdata_next = hit_x ? xfer_reg_rdata :
        (hit_v ? video_reg_rdata : '0);
  end
  assign xfer_reg_sel = hit_x;
  assign video_reg_sel = hit_v;
  // write strobe and data go out raw; the selects qualify them
  assign periph_reg_write = risc_reg_write;
  assign periph_reg_offset = risc_reg_addr[7:0];
  assign periph_reg_wdata = risc_reg_wdata;
  assign risc_reg_ready = ack_reg;
  assign risc_reg_rdata = rdata_reg;

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule

// *** tb/ocx_periph_model.sv ***
// register model of the transfer and video controllers
module ocx_periph_model (
  input wire logic [7:0] periph_reg_offset,
  output logic [31:0] xfer_reg_rdata,
  output logic [31:0] video_reg_rdata
);
  // offset folded in so a wrong decode shows
  assign xfer_reg_rdata = {24'hA5A5A5, periph_reg_offset};
  assign video_reg_rdata = {24'h5A5A5A, periph_reg_offset};
endmodule

// *** tb/ocx_crossbar_checker.sv ***
// port assertions for the crossbar
module ocx_crossbar_checker #(
  parameter int unsigned NB = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [14:0] req_valid,
  input wire logic [479:0] req_addr,
  input wire logic [14:0] req_grant,
  input wire logic [14:0] req_external,
  input wire logic [NB-1:0] bank_en,
  input wire logic risc_reg_valid,
  input wire logic risc_reg_ready,
  input wire logic xfer_reg_sel,
  input wire logic video_reg_sel,
  input wire logic [31:0] risc_reg_wdata,
  input wire logic [31:0] periph_reg_wdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_won0;
    req_valid == 15'h0021 && req_addr[191:0] == '0 && req_grant[0];
  endsequence
  stray_grant_a: assert property ((req_grant & ~req_valid) == '0)
    else $error("stray grant");
  ext_nogrant_a: assert property ((req_grant & req_external) == '0)
    else $error("external granted");
  bank_count_a:
    assert property ($countones(bank_en) == $countones(req_grant))
    else $error("bank count");
  reg_answer_a: assert property (risc_reg_valid |=> risc_reg_ready)
    else $error("no ready");
  ready_pulse_a: assert property (!risc_reg_valid |=> !risc_reg_ready)
    else $error("stray ready");
  one_sel_a: assert property (!(xfer_reg_sel && video_reg_sel))
    else $error("two selects");
  wdata_pass_a:
    assert property (video_reg_sel |-> periph_reg_wdata == risc_reg_wdata)
    else $error("wdata");
  rr_rotate_a:
    assert property (s_won0 ##1 $stable(req_valid) |-> req_grant[5])
    else $error("no rotation");
endmodule
bind ocx_crossbar ocx_crossbar_checker #(.NB(NB)) i_ocx_crossbar_checker (.*);

// *** tb/tb_ocx_crossbar.sv ***
// self-checking bench for the crossbar
module tb_ocx_crossbar;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, rst_n = 0, rv = 0, rw = 0;
  logic [14:0] v = '0, g, ext;
  logic [479:0] a = '0;
  logic [31:0] ra = '0, wd = '0, rd, xd, vd, pwd;
  logic [7:0] po;
  logic rdy, xs, vs, pw;
  logic [15:0] be;
  logic [511:0] bad;
  logic [63:0] bown;
  int err_count = 0, check_count = 0, cyc = 0;
  ocx_crossbar i_ocx_crossbar (.mclk(mclk), .rst_n(rst_n), .req_valid(v),
    .req_addr(a), .req_grant(g), .req_external(ext), .bank_en(be),
    .bank_addr(bad), .bank_owner(bown), .risc_reg_valid(rv),
    .risc_reg_write(rw), .risc_reg_addr(ra), .risc_reg_wdata(wd),
    .risc_reg_ready(rdy), .risc_reg_rdata(rd), .xfer_reg_sel(xs),
    .video_reg_sel(vs), .periph_reg_write(pw), .periph_reg_offset(po),
    .periph_reg_wdata(pwd), .xfer_reg_rdata(xd), .video_reg_rdata(vd));
  ocx_periph_model i_ocx_periph_model (.periph_reg_offset(po),
    .xfer_reg_rdata(xd), .video_reg_rdata(vd));
  always #2.5 mclk = ~mclk;
  task chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task t_contend;
    @(posedge mclk);
    v <= 15'h0021;
    #1 chk(g === 15'h0001, "first winner");
    chk(be === 16'h0001 && bown[3:0] === 4'h0, "first owner");
    @(posedge mclk);
    #1 chk(g === 15'h0020, "rotated winner");
    chk(be === 16'h0001 && bown[3:0] === 4'h5, "rotated owner");
  endtask
  task t_full;
    @(posedge mclk);
    for (int r = 0; r < 15; r++)
      a[r*32 +: 32] <= 32'(r) << 11;
    v <= 15'h7FFF;
    #1 chk(g === 15'h7FFF, "all ports");
    chk(be === 16'h7FFF && bown[59:56] === 4'hE, "bank owner");
    chk(bad[479:448] === 32'h0000_7000, "bank address");
  endtask
  task t_ext;
    @(posedge mclk);
    a[63:0] <= {32'h01FF_FFFC, 32'h0200_0000};
    v <= 15'h0003;
    #1 chk(g === 15'h0000 && ext === 15'h0001, "external");
  endtask
  task t_reg;
    @(posedge mclk);
    v <= '0;
    rv <= 1'b1;
    rw <= 1'b0;
    ra <= 32'h0100_0104;
    #1 chk(vs === 1'b1 && xs === 1'b0 && po === 8'h04, "video select");
    @(posedge mclk);
    rv <= 1'b0;
    #1 chk(rdy === 1'b1 && rd === 32'h5A5A_5A04, "video read");
  endtask
  task t_xfer;
    @(posedge mclk);
    rv <= 1'b1;
    ra <= 32'h0100_0010;
    #1 chk(xs === 1'b1 && vs === 1'b0 && pw === 1'b0, "xfer select");
    @(posedge mclk);
    rv <= 1'b0;
    #1 chk(rdy === 1'b1 && rd === 32'hA5A5_A510, "transfer read");
  endtask
  task t_wr;
    @(posedge mclk);
    rv <= 1'b1;
    rw <= 1'b1;
    ra <= 32'h0100_0020;
    wd <= 32'h1234_5678;
    #1 chk(xs === 1'b1 && pw === 1'b1, "write strobe");
    chk(pwd === 32'h1234_5678 && po === 8'h20, "write data");
    @(posedge mclk);
    rv <= 1'b0;
    rw <= 1'b0;
    #1 chk(rdy === 1'b1 && rd === 32'hA5A5_A510, "read data held");
  endtask
  task t_unmapped;
    @(posedge mclk);
    rv <= 1'b1;
    ra <= 32'h0100_0200;
    #1 chk(xs === 1'b0 && vs === 1'b0, "no select");
    @(posedge mclk);
    rv <= 1'b0;
    #1 chk(rdy === 1'b1 && rd === 32'h0000_0000, "unmapped read");
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // generous ceiling, the run needs about 27 cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 500)
    begin
      err_count++;
      give_verdict;
    end
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_contend;
    t_full;
    t_ext;
    t_reg;
    t_xfer;
    t_wr;
    t_unmapped;
    give_verdict;
  end
endmodule
